//--- verilog/dbm_top.sv
/*
  Control logic of a dual H-bridge motor driver: step/direction indexer
  with selectable microstep resolution, phase/enable operation, decay
  selection per coil, over-temperature disable and sleep reset.
  Assumes all pin inputs are asynchronous to clk; reference levels come
  from converter logic on clk. Three-state pins arrive as level plus an
  open-pin detect.
*/
`timescale 1ns/1ps
`include "dbm_cfg.svh"

module dbm_top
#(
  parameter logic [17:0] MODE_TABLE = `DBM_MODE_TABLE
)
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     step_in,
  input  wire logic                     dir_in,
  input  wire logic                     step_mode_sel_a,
  input  wire logic                     step_mode_sel_a_open,
  input  wire logic                     step_mode_sel_b,
  input  wire logic                     indexer_cfg,
  input  wire logic [1:0]               phase_in,
  input  wire logic [1:0]               bridge_drive_gate,
  input  wire logic [1:0]               decay_select_pin,
  input  wire logic [1:0]               decay_select_pin_open,
  input  wire logic                     over_temp,
  input  wire logic                     low_power_request_n,
  input  wire logic [`DBM_LEVEL_W-1:0]  vref_a,
  input  wire logic [`DBM_LEVEL_W-1:0]  vref_b,
  output dbm_pkg::dbm_coil_out_t [1:0]  coil_out,
  output logic [`DBM_POS_W-1:0]         indexer_pos,
  output logic                          fault_n
);

  typedef struct packed {
    dbm_pkg::dbm_pins_t     pin_s1;
    dbm_pkg::dbm_pins_t     pin_s2;
    logic                   step_d;
    logic [`DBM_POS_W-1:0]  pos;
    logic                   fault_n;
  } dbm_state_t;

  // quarter-wave sine, 33 points, full scale 255
  localparam logic [7:0] SINE_Q [0:32] = '{
    8'h00, 8'h0d, 8'h19, 8'h25, 8'h32, 8'h3e, 8'h4a, 8'h56,
    8'h62, 8'h6d, 8'h78, 8'h83, 8'h8e, 8'h98, 8'ha2, 8'hab,
    8'hb4, 8'hbd, 8'hc5, 8'hcd, 8'hd4, 8'hdb, 8'he1, 8'he7,
    8'hec, 8'hf0, 8'hf4, 8'hf7, 8'hfa, 8'hfc, 8'hfe, 8'hff,
    8'hff
  };

  dbm_state_t              state_reg;
  dbm_state_t              state_next;
  dbm_pkg::dbm_pins_t      pins_raw;
  dbm_pkg::dbm_pins_t      pins;
  dbm_pkg::dbm_res_t       res;
  logic [`DBM_POS_W-1:0]   step_inc;
  dbm_pkg::dbm_coil_cmd_t  cmd [2];
  logic [`DBM_LEVEL_W-1:0] vref [2];
  logic [`DBM_POS_W-1:0]   coil_angle [2];

  // magnitude of the sine at a position in the 128-step cycle
  function automatic logic [7:0] sine_mag(input logic [`DBM_POS_W-1:0] p);
    logic [5:0] idx;
    idx = p[5] ? 6'(6'h20 - {1'b0, p[4:0]}) : {1'b0, p[4:0]};
    return SINE_Q[idx];
  endfunction : sine_mag

  // second half of the cycle reverses current
  function automatic logic sine_pos(input logic [`DBM_POS_W-1:0] p);
    return ~p[6];
  endfunction : sine_pos

  function automatic dbm_pkg::dbm_res_t mode_lookup(input logic lvl_a,
                                                    input logic open_a,
                                                    input logic lvl_b);
    logic [2:0] a_state;
    logic [2:0] idx;
    a_state = open_a ? 3'h2 : {2'h0, lvl_a};
    idx     = lvl_b ? 3'(a_state + 3'h3) : a_state;
    return dbm_pkg::dbm_res_t'(MODE_TABLE[idx*3 +: 3]);
  endfunction : mode_lookup

  assign pins_raw = '{step: step_in, dir: dir_in,
                      sel_a_lvl: step_mode_sel_a,
                      sel_a_z: step_mode_sel_a_open,
                      sel_b: step_mode_sel_b, indexer_cfg: indexer_cfg,
                      phase: phase_in, gate: bridge_drive_gate,
                      dec_lvl: decay_select_pin,
                      dec_z: decay_select_pin_open,
                      over_temp: over_temp, awake: low_power_request_n};

  assign pins = state_reg.pin_s2;
  assign res  = mode_lookup(pins.sel_a_lvl, pins.sel_a_z, pins.sel_b);
  // coarser modes take larger strides through the same table
  assign step_inc = `DBM_FULL_INC >> res;

  always_comb
  begin
    state_next        = state_reg;
    state_next.pin_s1 = pins_raw;
    state_next.pin_s2 = state_reg.pin_s1;
    // tracking step while asleep avoids a phantom edge on wake
    state_next.step_d = pins.step;
    state_next.fault_n = pins.awake & ~pins.over_temp;
    if (!pins.awake)
      state_next.pos = `DBM_HOME_POS;
    else if (pins.indexer_cfg && pins.step && !state_reg.step_d)
    begin
      if (pins.dir)
        state_next.pos = state_reg.pos + step_inc;
      else
        state_next.pos = state_reg.pos - step_inc;
    end
  end

  assign vref[0]       = vref_a;
  assign vref[1]       = vref_b;
  // coil b leads coil a by a quarter cycle
  assign coil_angle[0] = state_reg.pos;
  assign coil_angle[1] = state_reg.pos + `DBM_QUARTER_POS;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_coil
      logic [15:0] scaled;
      assign scaled = vref[gi] * sine_mag(coil_angle[gi]);

      always_comb
      begin
        cmd[gi].dec_lvl = pins.dec_lvl[gi];
        cmd[gi].dec_z   = pins.dec_z[gi];
        if (!pins.awake || pins.over_temp)
        begin
          cmd[gi].run      = 1'b0;
          cmd[gi].dir      = 1'b0;
          cmd[gi].idle_off = 1'b1;
          cmd[gi].level    = `DBM_LEVEL_RST;
        end
        else if (pins.indexer_cfg)
        begin
          cmd[gi].run      = 1'b1;
          cmd[gi].dir      = sine_pos(coil_angle[gi]);
          cmd[gi].idle_off = 1'b1;
          cmd[gi].level    = scaled[15:8];
        end
        else
        begin
          // stepper patterns are sequenced by the controller
          cmd[gi].run      = pins.gate[gi];
          cmd[gi].dir      = pins.phase[gi];
          cmd[gi].idle_off = pins.sel_b;
          cmd[gi].level    = vref[gi];
        end
      end

      dbm_bridge_out u_bridge
      (
        .clk   (clk),
        .rst_n (rst_n),
        .cmd   (cmd[gi]),
        .out   (coil_out[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg         <= '0;
      state_reg.pos     <= `DBM_HOME_POS;
      state_reg.fault_n <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  assign indexer_pos = state_reg.pos;
  assign fault_n     = state_reg.fault_n;

endmodule : dbm_top

//--- verilog/dbm_cfg.svh
/*
  Constants of the dual-bridge motor control logic: indexer geometry, home
  position, reset values and the default step-mode table.
  Assumes inclusion by bare name from package and modules.
*/
`ifndef DBM_CFG_SVH
`define DBM_CFG_SVH

// electrical cycle is 128 microsteps of 1/32 step
`define DBM_POS_W        7
`define DBM_HOME_POS     7'h10
`define DBM_QUARTER_POS  7'h20
`define DBM_FULL_INC     7'h20
`define DBM_LEVEL_W      8
`define DBM_LEVEL_RST    8'h00
// step-mode table index = sel_b*3 + sel_a state (0 low, 1 high, 2 open)
`define DBM_MODE_TABLE   {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}

`endif

//--- verilog/dbm_pkg.sv
/*
  Types of the dual-bridge motor control logic.
  Assumes dbm_cfg.svh for widths.
*/
`include "dbm_cfg.svh"

package dbm_pkg;

  typedef enum logic [2:0] {
    DBM_RES_FULL    = 3'h0,
    DBM_RES_HALF    = 3'h1,
    DBM_RES_QUARTER = 3'h2,
    DBM_RES_EIGHTH  = 3'h3,
    DBM_RES_16TH    = 3'h4,
    DBM_RES_32ND    = 3'h5
  } dbm_res_t;

  typedef enum logic [1:0] {
    DBM_DECAY_SLOW  = 2'h0,
    DBM_DECAY_FAST  = 2'h1,
    DBM_DECAY_MIXED = 2'h2
  } dbm_decay_t;

  typedef enum logic [1:0] {
    DBM_DRV_OFF   = 2'h0,
    DBM_DRV_FWD   = 2'h1,
    DBM_DRV_REV   = 2'h2,
    DBM_DRV_BRAKE = 2'h3
  } dbm_drive_t;

  typedef struct packed {
    logic       step;
    logic       dir;
    logic       sel_a_lvl;
    logic       sel_a_z;
    logic       sel_b;
    logic       indexer_cfg;
    logic [1:0] phase;
    logic [1:0] gate;
    logic [1:0] dec_lvl;
    logic [1:0] dec_z;
    logic       over_temp;
    logic       awake;
  } dbm_pins_t;

  typedef struct packed {
    logic                     run;
    logic                     dir;
    logic                     idle_off;
    logic [`DBM_LEVEL_W-1:0]  level;
    logic                     dec_lvl;
    logic                     dec_z;
  } dbm_coil_cmd_t;

  typedef struct packed {
    dbm_drive_t               drive;
    dbm_decay_t               decay;
    logic [`DBM_LEVEL_W-1:0]  level;
  } dbm_coil_out_t;

endpackage : dbm_pkg

//--- verilog/dbm_bridge_out.sv
/*
  Output stage of one H-bridge: drive state, decay mode and current level.
  Assumes a command from logic on the same clock; decay pin already synced.
*/
`timescale 1ns/1ps
`include "dbm_cfg.svh"

module dbm_bridge_out
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire dbm_pkg::dbm_coil_cmd_t cmd,
  output dbm_pkg::dbm_coil_out_t      out
);

  dbm_pkg::dbm_coil_out_t state_reg;
  dbm_pkg::dbm_coil_out_t state_next;

  always_comb
  begin
    state_next = state_reg;
    // decay pin is live, so it is decoded every cycle
    if (cmd.dec_z)
      state_next.decay = dbm_pkg::DBM_DECAY_MIXED;
    else if (cmd.dec_lvl)
      state_next.decay = dbm_pkg::DBM_DECAY_FAST;
    else
      state_next.decay = dbm_pkg::DBM_DECAY_SLOW;
    if (cmd.run)
    begin
      state_next.drive = cmd.dir ? dbm_pkg::DBM_DRV_FWD
                                 : dbm_pkg::DBM_DRV_REV;
      state_next.level = cmd.level;
    end
    else if (cmd.idle_off)
    begin
      state_next.drive = dbm_pkg::DBM_DRV_OFF;
      state_next.level = `DBM_LEVEL_RST;
    end
    else
    begin
      // enable low between pwm pulses recirculates: slow decay
      state_next.drive = dbm_pkg::DBM_DRV_BRAKE;
      state_next.decay = dbm_pkg::DBM_DECAY_SLOW;
      state_next.level = cmd.level;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '{drive: dbm_pkg::DBM_DRV_OFF,
                     decay: dbm_pkg::DBM_DECAY_SLOW,
                     level: `DBM_LEVEL_RST};
    else
      state_reg <= state_next;
  end

  assign out = state_reg;

endmodule : dbm_bridge_out

//--- sim/dbm_host_model.sv
/* Host controller model driving the logic pins.
   Assumes the caller waits on its tasks from one process. */
`timescale 1ns/1ps
module dbm_host
(
  input  wire logic  clk,
  output logic       step_in = 1'h0,
  output logic       dir_in = 1'h1,
  output logic [1:0] phase_in = 2'h0,
  output logic [1:0] bridge_drive_gate = 2'h0
);
  // each level held 4 clocks so the two-flop sync sees every edge
  task pulse(input logic d);
    @(negedge clk);
    dir_in = d;
    repeat (4) @(negedge clk);
    step_in = 1'h1;
    repeat (4) @(negedge clk);
    step_in = 1'h0;
    repeat (4) @(negedge clk);
  endtask : pulse
  task drive(input logic [1:0] p, input logic [1:0] g);
    @(negedge clk);
    phase_in = p;
    bridge_drive_gate = g;
    repeat (5) @(negedge clk);
  endtask : drive
endmodule : dbm_host

//--- sim/dbm_top_chk.sv
/* Checker of dbm_top pin behaviour.
   Assumes it is bound into dbm_top. */
`timescale 1ns/1ps
`include "dbm_cfg.svh"
module dbm_top_chk
(
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         step_in,
  input wire logic                         dir_in,
  input wire logic                         indexer_cfg,
  input wire logic                         step_mode_sel_b,
  input wire logic [1:0]                   phase_in,
  input wire logic [1:0]                   bridge_drive_gate,
  input wire logic                         over_temp,
  input wire logic                         low_power_request_n,
  input wire logic [`DBM_LEVEL_W-1:0]      vref_b,
  input wire dbm_pkg::dbm_coil_out_t [1:0] coil_out,
  input wire logic [`DBM_POS_W-1:0]        indexer_pos,
  input wire logic                         fault_n
);
  wire ok = low_power_request_n && !over_temp;
  wire pe = ok && !indexer_cfg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // step spacing lets the prior move settle before $past looks back
  step_fwd_a: assert property (
    $rose(step_in) && dir_in && indexer_cfg && ok
    |-> ##4 $onehot(indexer_pos - $past(indexer_pos, 4)))
    else $error("bad forward step");
  step_rev_a: assert property (
    $rose(step_in) && !dir_in && indexer_cfg && ok
    |-> ##4 $onehot($past(indexer_pos, 4) - indexer_pos))
    else $error("bad reverse step");
  sleep_home_a: assert property (!low_power_request_n [*4]
    |=> indexer_pos == `DBM_HOME_POS && !fault_n)
    else $error("sleep not homed");
  hot_off_a: assert property (over_temp [*4] |=> !fault_n
    && coil_out[0].drive == dbm_pkg::DBM_DRV_OFF)
    else $error("live while hot");
  hot_resume_a: assert property (ok [*4] |=> fault_n)
    else $error("fault stuck");
  gate_zero_a: assert property (
    (pe && !bridge_drive_gate[0] && step_mode_sel_b) [*4]
    |=> coil_out[0].drive == dbm_pkg::DBM_DRV_OFF
    && coil_out[0].level == 8'h00)
    else $error("gate off not zero");
  gate_brake_a: assert property (
    (pe && !bridge_drive_gate[1] && !step_mode_sel_b) [*4]
    |=> coil_out[1].drive == dbm_pkg::DBM_DRV_BRAKE
    && coil_out[1].decay == dbm_pkg::DBM_DECAY_SLOW)
    else $error("no slow brake");
  phase_rev_a: assert property (
    (pe && bridge_drive_gate[1] && !phase_in[1] && $stable(vref_b)) [*4]
    |=> coil_out[1].drive == dbm_pkg::DBM_DRV_REV
    && coil_out[1].level == vref_b)
    else $error("bad phase drive");
endmodule : dbm_top_chk
bind dbm_top dbm_top_chk u_chk
(
  .clk(clk), .rst_n(rst_n), .step_in(step_in), .dir_in(dir_in),
  .indexer_cfg(indexer_cfg), .step_mode_sel_b(step_mode_sel_b),
  .phase_in(phase_in), .bridge_drive_gate(bridge_drive_gate),
  .over_temp(over_temp), .low_power_request_n(low_power_request_n),
  .vref_b(vref_b), .coil_out(coil_out), .indexer_pos(indexer_pos),
  .fault_n(fault_n)
);

//--- sim/test_dual_bridge_motor_control_logic.sv
/* Bench of dbm_top: pin scenarios through the host model.
   Assumes the default step-mode table. */
`timescale 1ns/1ps
`include "dbm_cfg.svh"
module test_dual_bridge_motor_control_logic;
  logic                         clk = 1'h0, rst_n = 1'h0;
  logic                         sa = 1'h0, sz = 1'h0, sb = 1'h0;
  logic                         cfg = 1'h1, hot = 1'h0, wake = 1'h1;
  logic [1:0]                   dl = 2'h0, dz = 2'h0;
  logic [7:0]                   va = 8'h9c, vb = 8'h47;
  logic [`DBM_POS_W-1:0]        e = `DBM_HOME_POS;
  wire                          step, dir, fault_n;
  wire [1:0]                    ph, gt;
  wire [`DBM_POS_W-1:0]         pos;
  dbm_pkg::dbm_coil_out_t [1:0] co;
  int                           err_count = 0, tests_run = 0, cyc = 0;
  dbm_host u_host (.clk(clk), .step_in(step), .dir_in(dir), .phase_in(ph),
    .bridge_drive_gate(gt));
  dbm_top u_dut (.clk(clk), .rst_n(rst_n), .step_in(step), .dir_in(dir),
    .step_mode_sel_a(sa), .step_mode_sel_a_open(sz), .step_mode_sel_b(sb),
    .indexer_cfg(cfg), .phase_in(ph), .bridge_drive_gate(gt),
    .decay_select_pin(dl), .decay_select_pin_open(dz), .over_temp(hot),
    .low_power_request_n(wake), .vref_a(va), .vref_b(vb), .coil_out(co),
    .indexer_pos(pos), .fault_n(fault_n));
  initial
  begin
    forever #10 clk = ~clk;
  end
  // full run takes about 264 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("mismatches %0d of %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task chk(input logic [11:0] g, input logic [11:0] x);
    tests_run++;
    if (g !== x)
    begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  task coil(input int i, input dbm_pkg::dbm_drive_t d,
    input dbm_pkg::dbm_decay_t y, input logic [7:0] l);
    chk(co[i], {d, y, l});
  endtask : coil
  initial
  begin
    repeat (8) @(negedge clk);
    chk({4'h0, pos, fault_n}, {4'h0, e, 1'h0});
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    for (int m = 0; m < 6; m++)
    begin
      sb = m > 2;
      sa = m % 3 == 1;
      sz = m % 3 == 2;
      e = e + (7'h20 >> m);
      u_host.pulse(1'h1);
      chk({5'h0, pos}, {5'h0, e});
      // one reverse step undoes the forward step of the same size
      e = e - (7'h20 >> m);
      u_host.pulse(1'h0);
      chk({5'h0, pos}, {5'h0, e});
    end
    // home sits at 45 degrees: both coils at 0xb4 of full scale
    coil(0, dbm_pkg::DBM_DRV_FWD, dbm_pkg::DBM_DECAY_SLOW, 8'h6d);
    coil(1, dbm_pkg::DBM_DRV_FWD, dbm_pkg::DBM_DECAY_SLOW, 8'h31);
    wake = 1'h0;
    u_host.pulse(1'h1);
    chk({4'h0, pos, fault_n}, {4'h0, `DBM_HOME_POS, 1'h0});
    wake = 1'h1;
    u_host.pulse(1'h1);
    chk({5'h0, pos}, {5'h0, `DBM_HOME_POS + 7'h01});
    cfg = 1'h0;
    for (int k = 0; k < 8; k++)
    begin
      if (k % 2 == 0)
        u_host.drive(2'(k ^ (k >> 1)), 2'h3);
      coil(k % 2, ph[k % 2] ? dbm_pkg::DBM_DRV_FWD : dbm_pkg::DBM_DRV_REV,
        dbm_pkg::DBM_DECAY_SLOW, k % 2 ? vb : va);
    end
    sb = 1'h1;
    u_host.drive(2'h3, 2'h2);
    coil(0, dbm_pkg::DBM_DRV_OFF, dbm_pkg::DBM_DECAY_SLOW, 8'h00);
    sb = 1'h0;
    u_host.drive(2'h3, 2'h1);
    coil(1, dbm_pkg::DBM_DRV_BRAKE, dbm_pkg::DBM_DECAY_SLOW, vb);
    for (int d = 0; d < 3; d++)
    begin
      dl = d == 1 ? 2'h3 : 2'h0;
      dz = d == 2 ? 2'h3 : 2'h0;
      u_host.drive(2'h3, 2'h1);
      coil(0, dbm_pkg::DBM_DRV_FWD, dbm_pkg::dbm_decay_t'(d), va);
    end
    hot = 1'h1;
    u_host.drive(2'h3, 2'h1);
    chk({9'h0, co[0].drive, fault_n}, {9'h0, 2'h0, 1'h0});
    hot = 1'h0;
    u_host.drive(2'h3, 2'h1);
    chk({9'h0, co[0].drive, fault_n}, {9'h0, 2'h1, 1'h1});
    print_verdict();
  end
endmodule : test_dual_bridge_motor_control_logic
